// ==== kbc_host_pkg.sv ====
package kbc_host_pkg;

  // Host I/O addresses
  localparam logic [15:0] data_port_addr      = 16'h0060;
  localparam logic [15:0] cmd_status_port_addr = 16'h0064;
  localparam logic [15:0] fast_gate_port_addr = 16'h0092;

  // Status register fields
  localparam int          obf_pos          = 0;
  localparam int          ibf_pos          = 1;
  localparam int          cmd_data_pos     = 3;
  localparam logic [7:0]  status_reset     = 8'h00;
  localparam logic [7:0]  status_gp_mask   = 8'hf4;

  // Fast gate register fields
  localparam int          alt_reset_pos    = 0;
  localparam int          alternate_a20_out_pos      = 1;
  localparam logic [7:0]  fast_gate_reset  = 8'h24;
  localparam logic [7:0]  fast_gate_fixed  = 8'h24;
  localparam int          gate_enable_pos  = 2;

  // Alternate reset timing
  localparam int          clk_mhz          = 25;
  localparam int          alt_delay_us     = 14;
  localparam int          alt_width_us     = 6;
  localparam int          alt_delay_cycles = alt_delay_us * clk_mhz;
  localparam int          alt_width_cycles = alt_width_us * clk_mhz;

  typedef enum logic [1:0] {
    pulse_idle,
    pulse_delay,
    pulse_low,
    pulse_done
  } pulse_state_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr_n;
    logic        rd_n;
  } host_bus_type;

  typedef struct packed {
    logic [7:0]  wdata;
    logic        data_wr;
    logic        data_rd;
    logic        status_wr;
  } cpu_bus_type;

endpackage

// ==== kbc_host_flags.sv ====
module kbc_host_flags #(
  parameter int delay_cycles = kbc_host_pkg::alt_delay_cycles,
  parameter int width_cycles = kbc_host_pkg::alt_width_cycles
) (
  input  wire logic                       core_clk,
  input  wire logic                       reset,
  input  wire kbc_host_pkg::host_bus_type host_bus,
  input  wire kbc_host_pkg::cpu_bus_type  cpu_bus,
  input  wire logic                       flag_mode,
  input  wire logic                       kbd_irq_port_bit,
  input  wire logic                       mouse_irq_port_bit,
  input  wire logic                       kbd_reset_gate_config,
  input  wire logic                       controller_reset_n,
  input  wire logic                       reset_polarity,
  input  wire logic                       timer_overflow,
  input  wire logic                       ibf_irq_enable,
  input  wire logic                       timer_irq_enable,
  output logic [7:0]                      host_rdata,
  output logic                            host_rdata_oe,
  output logic [7:0]                      cpu_data_buffer,
  output logic [7:0]                      cpu_status,
  output logic                            cpu_ibf_irq,
  output logic                            cpu_timer_irq,
  output logic                            keyboard_irq_out,
  output logic                            mouse_irq_out,
  output logic                            alternate_a20_out,
  output logic                            alternate_reset_n,
  output logic                            keyboard_reset_pin
);

  // Counts must fit the 16-bit pulse counter
  if (delay_cycles < 1 || width_cycles < 1 || delay_cycles > 65535 || width_cycles > 65535) begin : g_bad_counts
    $error("pulse counts out of range");
  end

  typedef struct packed {
    logic [2:0]                    sync_wr;
    logic [2:0]                    sync_rd;
    logic [7:0]                    in_buf;
    logic [7:0]                    out_buf;
    logic [7:0]                    status;
    logic [1:0]                    gate_bits;
    logic                          irq_latch;
    kbc_host_pkg::pulse_state_type pstate;
    logic [15:0]                   count;
    logic [7:0]                    host_rdata;
    logic                          host_rdata_oe;
    logic                          ibf_irq;
    logic                          timer_irq;
    logic                          kbd_irq;
    logic                          mouse_irq;
    logic                          a20;
    logic                          alt_rst_n;
    logic                          kbd_rst;
    logic                          gate_en;
  } state_type;

  state_type q;
  state_type d;
  logic      wr_edge;
  logic      rd_active;
  logic      sel_data;
  logic      sel_cmd;
  logic      sel_gate;
  logic      combined_n;

  // Host strobes come from the ISA domain; address and data are sampled on the strobe edge
  // after two flops, relying on the bus holding them through the cycle.
  always_comb begin
    d = q;
    d.sync_wr = {q.sync_wr[1:0], ~host_bus.wr_n};
    d.sync_rd = {q.sync_rd[1:0], ~host_bus.rd_n};
    d.gate_en = kbd_reset_gate_config;
    wr_edge   = q.sync_wr[1] & ~q.sync_wr[2];
    rd_active = q.sync_rd[1];
    sel_data  = host_bus.addr == kbc_host_pkg::data_port_addr;
    sel_cmd   = host_bus.addr == kbc_host_pkg::cmd_status_port_addr;
    sel_gate  = (host_bus.addr == kbc_host_pkg::fast_gate_port_addr) && q.gate_en;

    if (cpu_bus.status_wr) begin
      d.status = cpu_bus.wdata;
    end
    if (cpu_bus.data_rd) begin
      d.status[kbc_host_pkg::ibf_pos] = 1'b0;
    end
    if (cpu_bus.data_wr) begin
      d.out_buf = cpu_bus.wdata;
      d.irq_latch = 1'b1;
    end
    if (wr_edge && (sel_data || sel_cmd)) begin
      d.in_buf = host_bus.wdata;
      d.status[kbc_host_pkg::ibf_pos] = 1'b1;
      d.status[kbc_host_pkg::cmd_data_pos] = host_bus.addr[2];
    end
    if (rd_active && !q.sync_rd[2] && sel_data && flag_mode && !cpu_bus.data_wr) begin
      d.irq_latch = 1'b0;
      if (!cpu_bus.status_wr) begin
        d.status[kbc_host_pkg::obf_pos] = 1'b0;
      end
    end
    if (cpu_bus.data_wr) begin
      d.status[kbc_host_pkg::obf_pos] = 1'b1;
    end
    if (wr_edge && sel_gate) begin
      d.gate_bits = host_bus.wdata[1:0];
    end

    d.host_rdata_oe = rd_active && (sel_data || sel_cmd || sel_gate);
    if (sel_data) begin
      d.host_rdata = q.out_buf;
    end else if (sel_cmd) begin
      d.host_rdata = q.status;
    end else if (sel_gate) begin
      d.host_rdata = kbc_host_pkg::fast_gate_fixed | {6'h00, q.gate_bits};
    end else begin
      d.host_rdata = 8'h00;
    end

    case (q.pstate)
      kbc_host_pkg::pulse_idle: begin
        if (q.gate_bits[kbc_host_pkg::alt_reset_pos]) begin
          d.pstate = kbc_host_pkg::pulse_delay;
          d.count  = 16'(delay_cycles - 1);
        end
      end
      kbc_host_pkg::pulse_delay: begin
        if (q.count == 16'h0000) begin
          d.pstate = kbc_host_pkg::pulse_low;
          d.count  = 16'(width_cycles - 1);
        end else begin
          d.count = q.count - 16'h0001;
        end
      end
      kbc_host_pkg::pulse_low: begin
        if (q.count == 16'h0000) begin
          d.pstate = kbc_host_pkg::pulse_done;
        end else begin
          d.count = q.count - 16'h0001;
        end
      end
      default: begin
        // Rearm only after bit 0 clears
        if (!q.gate_bits[kbc_host_pkg::alt_reset_pos]) begin
          d.pstate = kbc_host_pkg::pulse_idle;
        end
      end
    endcase

    d.alt_rst_n = (d.pstate != kbc_host_pkg::pulse_low);
    d.a20 = d.gate_bits[kbc_host_pkg::alternate_a20_out_pos];
    combined_n = controller_reset_n & (d.alt_rst_n | ~q.gate_en);
    d.kbd_rst  = reset_polarity ? ~combined_n : combined_n;

    d.kbd_irq = flag_mode ? (kbd_irq_port_bit & d.irq_latch) : kbd_irq_port_bit;
    d.mouse_irq = (flag_mode && mouse_irq_port_bit) ? ~d.status[kbc_host_pkg::ibf_pos] : mouse_irq_port_bit;
    d.ibf_irq   = ibf_irq_enable & d.status[kbc_host_pkg::ibf_pos];
    d.timer_irq = timer_irq_enable & (q.timer_irq | timer_overflow);
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      q.sync_wr       <= 3'h0;
      q.sync_rd       <= 3'h0;
      q.status        <= kbc_host_pkg::status_reset;
      q.gate_bits     <= kbc_host_pkg::fast_gate_reset[1:0];
      q.irq_latch     <= 1'b0;
      q.pstate        <= kbc_host_pkg::pulse_idle;
      q.count         <= 16'h0000;
      q.host_rdata    <= 8'h00;
      q.host_rdata_oe <= 1'b0;
      q.ibf_irq       <= 1'b0;
      q.timer_irq     <= 1'b0;
      q.kbd_irq       <= 1'b0;
      q.mouse_irq     <= 1'b0;
      q.a20           <= 1'b0;
      q.alt_rst_n     <= 1'b1;
      q.kbd_rst       <= 1'b0;
      q.gate_en       <= 1'b0;
    end else begin
      q.sync_wr       <= d.sync_wr;
      q.sync_rd       <= d.sync_rd;
      q.in_buf        <= d.in_buf;
      q.out_buf       <= d.out_buf;
      q.status        <= d.status;
      q.gate_bits     <= d.gate_bits;
      q.irq_latch     <= d.irq_latch;
      q.pstate        <= d.pstate;
      q.count         <= d.count;
      q.host_rdata    <= d.host_rdata;
      q.host_rdata_oe <= d.host_rdata_oe;
      q.ibf_irq       <= d.ibf_irq;
      q.timer_irq     <= d.timer_irq;
      q.kbd_irq       <= d.kbd_irq;
      q.mouse_irq     <= d.mouse_irq;
      q.a20           <= d.a20;
      q.alt_rst_n     <= d.alt_rst_n;
      q.kbd_rst       <= d.kbd_rst;
      q.gate_en       <= d.gate_en;
    end
  end

  assign cpu_data_buffer    = q.in_buf;
  assign cpu_status         = q.status;
  assign cpu_ibf_irq        = q.ibf_irq;
  assign cpu_timer_irq      = q.timer_irq;
  assign host_rdata         = q.host_rdata;
  assign host_rdata_oe      = q.host_rdata_oe;
  assign keyboard_irq_out   = q.kbd_irq;
  assign mouse_irq_out      = q.mouse_irq;
  assign alternate_a20_out  = q.a20;
  assign alternate_reset_n  = q.alt_rst_n;
  assign keyboard_reset_pin = q.kbd_rst;

endmodule

// ==== kbc_host_flags_checker.sv ====
module kbc_host_flags_checker #(
  parameter int width_cycles = 3
) (
  input wire logic                      core_clk,
  input wire logic                      reset,
  input wire kbc_host_pkg::cpu_bus_type cpu_bus,
  input wire logic                      flag_mode,
  input wire logic                      kbd_irq_port_bit,
  input wire logic                      kbd_reset_gate_config,
  input wire logic                      controller_reset_n,
  input wire logic                      reset_polarity,
  input wire logic                      timer_overflow,
  input wire logic                      timer_irq_enable,
  input wire logic                      ibf_irq_enable,
  input wire logic [7:0]                cpu_status,
  input wire logic                      cpu_ibf_irq,
  input wire logic                      cpu_timer_irq,
  input wire logic                      keyboard_irq_out,
  input wire logic                      alternate_a20_out,
  input wire logic                      alternate_reset_n,
  input wire logic                      keyboard_reset_pin
);
  logic [15:0] low_cnt_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // Counter keeps the width check free of long repetitions
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) low_cnt_q <= 16'h0000;
    else low_cnt_q <= alternate_reset_n ? 16'h0000 : low_cnt_q + 16'h0001;
  end
  a_obf_on_write: assert property (cpu_bus.data_wr && !cpu_bus.status_wr |=> cpu_status[0])
    else $error("output full not set");
  a_kbd_irq_set: assert property (flag_mode && kbd_irq_port_bit && cpu_bus.data_wr |=> keyboard_irq_out)
    else $error("keyboard irq not raised");
  a_kbd_irq_port: assert property (!flag_mode |=> keyboard_irq_out == $past(kbd_irq_port_bit))
    else $error("keyboard irq not following port bit");
  a_gp_bits_write: assert property (cpu_bus.status_wr |=> (cpu_status & 8'hf4) == ($past(cpu_bus.wdata) & 8'hf4))
    else $error("general status bits lost");
  a_timer_irq_set: assert property (timer_irq_enable && timer_overflow |=> cpu_timer_irq)
    else $error("timer irq missing");
  a_ibf_irq_off: assert property (!ibf_irq_enable |=> !cpu_ibf_irq)
    else $error("input irq while disabled");
  a_pulse_width: assert property ($rose(alternate_reset_n) |-> low_cnt_q == width_cycles)
    else $error("alternate reset width wrong");
  a_a20_gated: assert property (!kbd_reset_gate_config |=> $stable(alternate_a20_out))
    else $error("a20 changed while gate disabled");
  a_kbd_pin_map: assert property (!kbd_reset_gate_config |=>
    keyboard_reset_pin == ($past(controller_reset_n) ^ $past(reset_polarity)))
    else $error("keyboard reset pin wrong");
  c_pulse: cover property ($fell(alternate_reset_n));
  c_kbd_irq: cover property ($rose(keyboard_irq_out));
  c_a20: cover property ($rose(alternate_a20_out));
endmodule
bind kbc_host_flags kbc_host_flags_checker #(.width_cycles(width_cycles)) u_chk (.*);

// ==== kbc_host_model.sv ====
module kbc_host_model (
  input wire logic                        core_clk,
  input wire logic [7:0]                  host_rdata,
  input wire logic                        host_rdata_oe,
  output     kbc_host_pkg::host_bus_type  host_bus
);
  timeunit 1ns;
  timeprecision 1ns;
  initial host_bus = {16'h0000, 8'h00, 1'b1, 1'b1};
  task automatic io(input logic [15:0] a, input logic [7:0] d, input logic w, output logic [8:0] r);
    @(negedge core_clk);
    host_bus = {a, d, !w, w};
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    r = {host_rdata_oe, host_rdata};
    // Released data no longer shows the old byte
    host_bus = {a, ~d, 1'b1, 1'b1};
    repeat (4) @(negedge core_clk);
  endtask
endmodule

// ==== kbc_host_flags_fast_gate_reset_test.sv ====
module kbc_host_flags_fast_gate_reset_test;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [15:0] a; logic [7:0] d; logic w; logic [8:0] r; logic [7:0] s; logic g;} row_type;
  logic core_clk, reset, flag_mode, kbd_irq_port_bit, mouse_irq_port_bit, kbd_reset_gate_config;
  logic controller_reset_n, reset_polarity, timer_overflow, ibf_irq_enable, timer_irq_enable;
  logic host_rdata_oe, cpu_ibf_irq, cpu_timer_irq, keyboard_irq_out, mouse_irq_out;
  logic alternate_a20_out, alternate_reset_n, keyboard_reset_pin;
  logic [7:0] host_rdata, cpu_data_buffer, cpu_status;
  logic [8:0] got;
  kbc_host_pkg::host_bus_type host_bus;
  kbc_host_pkg::cpu_bus_type  cpu_bus;
  int err_count, num_checks, cyc, n;
  row_type rows [8] = '{
    '{16'h0092, 8'h00, 1'b0, 9'h124, 8'h00, 1'b0}, '{16'h0092, 8'hfe, 1'b1, 9'h000, 8'h00, 1'b1},
    '{16'h0092, 8'h00, 1'b0, 9'h126, 8'h00, 1'b1}, '{16'h0060, 8'h5a, 1'b1, 9'h000, 8'h02, 1'b1},
    '{16'h0064, 8'hc3, 1'b1, 9'h000, 8'h0a, 1'b1}, '{16'h0064, 8'h00, 1'b0, 9'h10a, 8'h0a, 1'b1},
    '{16'h0070, 8'h00, 1'b0, 9'h000, 8'h0a, 1'b1}, '{16'h0092, 8'h00, 1'b1, 9'h000, 8'h0a, 1'b0}};
  kbc_host_model u_host (.core_clk(core_clk), .host_rdata(host_rdata), .host_rdata_oe(host_rdata_oe),
    .host_bus(host_bus));
  kbc_host_flags #(.delay_cycles(20), .width_cycles(5)) u_dut (.core_clk(core_clk), .reset(reset),
    .host_bus(host_bus), .cpu_bus(cpu_bus), .flag_mode(flag_mode), .kbd_irq_port_bit(kbd_irq_port_bit),
    .mouse_irq_port_bit(mouse_irq_port_bit), .kbd_reset_gate_config(kbd_reset_gate_config),
    .controller_reset_n(controller_reset_n), .reset_polarity(reset_polarity), .timer_overflow(timer_overflow),
    .ibf_irq_enable(ibf_irq_enable), .timer_irq_enable(timer_irq_enable), .host_rdata(host_rdata),
    .host_rdata_oe(host_rdata_oe), .cpu_data_buffer(cpu_data_buffer), .cpu_status(cpu_status),
    .cpu_ibf_irq(cpu_ibf_irq), .cpu_timer_irq(cpu_timer_irq), .keyboard_irq_out(keyboard_irq_out),
    .mouse_irq_out(mouse_irq_out), .alternate_a20_out(alternate_a20_out),
    .alternate_reset_n(alternate_reset_n), .keyboard_reset_pin(keyboard_reset_pin));
  task automatic chk(input string nm, input logic [8:0] s, input logic [8:0] e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cpu(input logic [2:0] p, input logic [7:0] d);
    @(negedge core_clk);
    cpu_bus = {d, p};
    @(negedge core_clk);
    cpu_bus = '0;
    @(negedge core_clk);
  endtask
  // Pulse seen or not within a bounded wait, then its width
  task automatic pulse_chk(input logic e);
    u_host.io(16'h0092, 8'h01, 1'b1, got);
    n = 0;
    while (alternate_reset_n === 1'b1 && n < 60) begin
      @(negedge core_clk);
      n++;
    end
    chk("pulse_seen", n < 60, e);
    if (e) chk("delay", n, 15);
    n = 0;
    while (alternate_reset_n === 1'b0) begin
      @(negedge core_clk);
      n++;
      if (n == 2) chk("kbd_pin", keyboard_reset_pin, 0);
    end
    if (e) chk("width", n, 5);
  endtask
  initial begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    {reset, kbd_irq_port_bit, mouse_irq_port_bit, kbd_reset_gate_config, controller_reset_n} = 5'h1f;
    {flag_mode, reset_polarity, timer_overflow, ibf_irq_enable, timer_irq_enable} = 5'h00;
    cpu_bus = '0;
    repeat (12) @(negedge core_clk);
    reset = 0;
    repeat (3) @(negedge core_clk);
    flag_mode = 1;
    foreach (rows[i]) begin
      u_host.io(rows[i].a, rows[i].d, rows[i].w, got);
      if (!rows[i].w) chk("rdata", rows[i].r[8] ? got : {got[8], 8'h00}, rows[i].r);
      chk("status", cpu_status, rows[i].s);
      chk("a20", alternate_a20_out, rows[i].g);
      // Controller gate bit held low, so the system mask follows the alternate output
      chk("a20_mask", 1'b0 | alternate_a20_out, rows[i].g);
    end
    cpu(3'b010, 8'h00);
    chk("cpu_rd", cpu_data_buffer, 8'hc3);
    chk("ibf_clr", cpu_status, 8'h08);
    cpu(3'b100, 8'h81);
    chk("obf_set", cpu_status, 8'h09);
    chk("keyboard_irq_out", keyboard_irq_out, 1);
    chk("mouse_irq_out", mouse_irq_out, 1);
    u_host.io(16'h0060, 8'h00, 1'b0, got);
    chk("out_rd", got, 9'h181);
    chk("obf_clr", {keyboard_irq_out, cpu_status}, 9'h008);
    cpu(3'b001, 8'hf7);
    chk("cpu_st", cpu_status, 8'hf7);
    ibf_irq_enable = 1;
    timer_irq_enable = 1;
    u_host.io(16'h0060, 8'h11, 1'b1, got);
    chk("ibf_irq", cpu_ibf_irq, 1);
    cpu(3'b000, 8'h00);
    timer_overflow = 1;
    @(negedge core_clk);
    timer_overflow = 0;
    @(negedge core_clk);
    chk("tmr_irq", cpu_timer_irq, 1);
    pulse_chk(1);
    pulse_chk(0);
    u_host.io(16'h0092, 8'h00, 1'b1, got);
    pulse_chk(1);
    kbd_reset_gate_config = 0;
    reset_polarity = 1;
    u_host.io(16'h0092, 8'h02, 1'b1, got);
    chk("a20_off", alternate_a20_out, 0);
    chk("pol", keyboard_reset_pin, 0);
    u_host.io(16'h0092, 8'h00, 1'b0, got);
    chk("no_oe", got[8], 0);
    // Mid-run reset held past the minimum length
    reset = 1;
    repeat (24) @(negedge core_clk);
    reset = 0;
    kbd_reset_gate_config = 1;
    @(negedge core_clk);
    chk("rst_st", cpu_status, 8'h00);
    chk("rst_buf", cpu_data_buffer, 8'h11);
    chk("rst_pins", {alternate_a20_out, alternate_reset_n}, 2'b01);
    u_host.io(16'h0092, 8'h00, 1'b0, got);
    chk("rst_92", got, 9'h124);
    finish_test();
  end
endmodule
